// ==== inc/pcw_pkg.sv ====
// What this block does
// - With the reference leading, the pump sources current when pump_polarity is 0 and sinks it when 1.
// - pump_midrail_preset at 1 keeps both pump_source and pump_sink low whatever the detector does; it resets to 0.
// - pump_current_code sits in bits 7:4 and resets to 4'b1010.
// - detector_pulse_width sits in bits 9:8 and resets to zero.
// - feedback_source_select sits in bits 12:10 and resets to 3'b101.
// - Five output_source_select fields of three bits fill bits 27:13, each resetting to 3'b101.
// - sleep_control_n at 0 powers the device down; it resets to 1.
// - shared_pin_role picks divider reset (0) or hold (1) for the shared pin; it resets to 0.
// - Bit 30 at 0 resets all dividers just like the pin; it resets to 1.
// - Bit 31 at 0 tri-states the pump just like the hold pin; it resets to 1.
package pcw_pkg;
	localparam int WORD_W = 32;
	localparam logic [1:0] SEL_THIS_WORD = 2'h2;
	localparam int SEL_LSB = 0;
	localparam int POL_BIT = 2;
	localparam int PRESET_BIT = 3;
	localparam int CUR_LSB = 4;
	localparam int CUR_W = 4;
	localparam int PFD_LSB = 8;
	localparam int PFD_W = 2;
	localparam int FB_LSB = 10;
	localparam int MUX_W = 3;
	localparam int OUT_LSB = 13;
	localparam int OUT_N = 5;
	localparam int SLEEP_BIT = 28;
	localparam int ROLE_BIT = 29;
	localparam int SWRST_BIT = 30;
	localparam int SWHOLD_BIT = 31;
	localparam logic [WORD_W-1:0] WORD_RESET = 32'hdb6db4a2;
	typedef struct packed {
		logic [1:0] clk_sync;
		logic [1:0] data_sync;
		logic [1:0] le_sync;
		logic [1:0] pin_sync;
		logic clk_prev;
		logic le_prev;
		logic [WORD_W-1:0] shift;
		logic [WORD_W-1:0] word;
	} pcw_state_t;
endpackage : pcw_pkg

// ==== rtl/pcw_config_word.sv ====
`timescale 1ns/100ps
module pcw_config_word (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Serial configuration pins
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_latch,
	// Shared reset or hold pin, active low
	input wire logic shared_pin_n,
	// Phase detector outputs
	input wire logic ref_leads,
	input wire logic fb_leads,
	// Charge pump control
	output logic pump_source,
	output logic pump_sink,
	output logic pump_tristate,
	output logic pump_midrail_preset,
	output logic pump_polarity,
	output logic [pcw_pkg::CUR_W-1:0] pump_current_code,
	output logic [pcw_pkg::PFD_W-1:0] detector_pulse_width,
	// Routing
	output logic [pcw_pkg::MUX_W-1:0] feedback_source_select,
	output logic [pcw_pkg::OUT_N*pcw_pkg::MUX_W-1:0] output_source_select,
	// Modes
	output logic sleep_control_n,
	output logic shared_pin_role,
	output logic divider_reset,
	// Whole word readout
	output logic [pcw_pkg::WORD_W-1:0] config_word
);
	import pcw_pkg::*;

	pcw_state_t s_q;
	pcw_state_t s_d;
	logic clk_rise;
	logic le_rise;
	logic pin_low;

	always_comb begin
		s_d = s_q;
		s_d.clk_sync = {s_q.clk_sync[0], ser_clk};
		s_d.data_sync = {s_q.data_sync[0], ser_data};
		s_d.le_sync = {s_q.le_sync[0], ser_latch};
		s_d.pin_sync = {s_q.pin_sync[0], shared_pin_n};
		s_d.clk_prev = s_q.clk_sync[1];
		s_d.le_prev = s_q.le_sync[1];
		clk_rise = s_q.clk_sync[1] & ~s_q.clk_prev;
		le_rise = s_q.le_sync[1] & ~s_q.le_prev;
		// Shift in, most significant bit first
		if (clk_rise) begin
			s_d.shift = {s_q.shift[WORD_W-2:0], s_q.data_sync[1]};
		end
		// Latch only words addressed to this register
		if (le_rise && s_q.shift[SEL_LSB+1:SEL_LSB] == SEL_THIS_WORD) begin
			s_d.word = s_q.shift;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s_q.clk_sync <= 2'h0;
			s_q.data_sync <= 2'h0;
			s_q.le_sync <= 2'h0;
			s_q.pin_sync <= 2'h3;
			s_q.clk_prev <= 1'h0;
			s_q.le_prev <= 1'h0;
			s_q.shift <= 32'h0;
			s_q.word <= WORD_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_low = ~s_q.pin_sync[1];
	assign config_word = s_q.word;
	assign pump_polarity = s_q.word[POL_BIT];
	assign pump_midrail_preset = s_q.word[PRESET_BIT];
	assign pump_current_code = s_q.word[CUR_LSB +: CUR_W];
	assign detector_pulse_width = s_q.word[PFD_LSB +: PFD_W];
	assign feedback_source_select = s_q.word[FB_LSB +: MUX_W];
	assign output_source_select = s_q.word[OUT_LSB +: OUT_N*MUX_W];
	assign sleep_control_n = s_q.word[SLEEP_BIT];
	assign shared_pin_role = s_q.word[ROLE_BIT];

	// Divider reset from software bit or pin in reset role
	assign divider_reset = ~s_q.word[SWRST_BIT] | (pin_low & ~s_q.word[ROLE_BIT]);

	// Pump floats on software hold, pin in hold role, or power-down
	assign pump_tristate = ~s_q.word[SWHOLD_BIT] | (pin_low & s_q.word[ROLE_BIT]) | ~s_q.word[SLEEP_BIT];

	// Direction of pump current; preset overrides detector pulses
	always_comb begin
		pump_source = 1'b0;
		pump_sink = 1'b0;
		if (!pump_tristate && !s_q.word[PRESET_BIT]) begin
			if (ref_leads && !fb_leads) begin
				pump_source = ~s_q.word[POL_BIT];
				pump_sink = s_q.word[POL_BIT];
			end else if (fb_leads && !ref_leads) begin
				pump_source = s_q.word[POL_BIT];
				pump_sink = ~s_q.word[POL_BIT];
			end
		end
	end
endmodule : pcw_config_word

// ==== sim/pcw_config_word_assertions.sv ====
`timescale 1ns/100ps
module pcw_checker import pcw_pkg::*; (
	// Watched ports
	input wire logic sys_clk, rstn, pump_tristate, pump_midrail_preset, sleep_control_n, divider_reset,
	input wire logic [WORD_W-1:0] config_word
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sel_code_a: assert property (config_word[1:0] == 2'h2) else $error("select");
	preset_bit_a: assert property (pump_midrail_preset == config_word[3]) else $error("preset");
	reset_word_a: assert property ($rose(rstn) |-> config_word == 32'hdb6db4a2) else $error("reset");
	sleep_bit_a: assert property (sleep_control_n == config_word[28]) else $error("sleep");
	sleep_tri_a: assert property (!config_word[28] |-> pump_tristate) else $error("sleep");
	role_hold_a: assert property (config_word[30] && config_word[29] |-> !divider_reset) else $error("role");
	div_reset_a: assert property (!config_word[30] |-> divider_reset) else $error("divider");
	sw_hold_a: assert property (!config_word[31] |-> pump_tristate) else $error("hold");
endmodule : pcw_checker
bind pcw_config_word pcw_checker u_chk (.*);

// ==== sim/pcw_host.sv ====
`timescale 1ns/100ps
module pcw_host (
	input wire logic sys_clk,
	output logic ser_clk = 1'h0, ser_data = 1'h0, ser_latch = 1'h0
);
	task send(input logic [31:0] w);
		for (int i = 31; i >= -1; i--) begin
			ser_data <= i < 0 ? ~ser_data : w[i];
			repeat (4) @(posedge sys_clk);
			{ser_latch, ser_clk} <= i < 0 ? 2'h2 : 2'h1;
			repeat (8) @(posedge sys_clk);
			{ser_latch, ser_clk} <= 2'h0;
		end
	endtask : send
endmodule : pcw_host

// ==== sim/test_pll_config_word_two.sv ====
`timescale 1ns/100ps
module test_pll_config_word_two;
	logic sys_clk = 1'h0, rstn = 1'h0, shared_pin_n = 1'h1, ser_clk, ser_data, ser_latch;
	logic [31:0] config_word, w, e = 32'hdb6db4a2;
	logic ref_leads = 1'h0, fb_leads = 1'h0;
	logic pump_source, pump_sink, pump_tristate, pump_midrail_preset, pump_polarity;
	logic sleep_control_n, shared_pin_role, divider_reset;
	logic [3:0] pump_current_code;
	logic [1:0] detector_pulse_width;
	logic [2:0] feedback_source_select;
	logic [14:0] output_source_select;
	int bad_count = 0, comparisons = 0;
	initial forever #12.5 sys_clk = ~sys_clk;
	pcw_host u_host (.*);
	pcw_config_word u_dut (.sys_clk, .rstn, .ser_clk, .ser_data, .ser_latch, .shared_pin_n,
		.ref_leads, .fb_leads, .pump_source, .pump_sink, .pump_tristate, .pump_midrail_preset, .pump_polarity,
		.pump_current_code, .detector_pulse_width, .feedback_source_select, .output_source_select,
		.sleep_control_n, .shared_pin_role, .divider_reset, .config_word);
	// Expected outputs from a stored word, the shared pin and the detector levels
	function automatic logic [31:0] want_outputs(input logic [31:0] cw, input logic pin_n, ref_l, fb_l);
		logic tri_w;
		logic src;
		logic snk;
		tri_w = ~cw[31] | (~pin_n & cw[29]) | ~cw[28];
		src = 1'h0;
		snk = 1'h0;
		if (!tri_w && !cw[3] && ref_l && !fb_l) begin
			src = ~cw[2];
			snk = cw[2];
		end else if (!tri_w && !cw[3] && fb_l && !ref_l) begin
			src = cw[2];
			snk = ~cw[2];
		end
		return {src, snk, tri_w, cw[3], cw[2], cw[7:4], cw[9:8], cw[27:10], cw[28], cw[29],
			~cw[30] | (~pin_n & ~cw[29])};
	endfunction : want_outputs
	task check(input logic [31:0] seen, want);
		comparisons++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD %0t word %h", $time, seen);
		end
	endtask : check
	task report_and_stop;
		if (bad_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (9000) @(posedge sys_clk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h5e43a402));
		repeat (3) @(posedge sys_clk);
		rstn <= 1'h1;
		for (int i = 0; i < 16; i++) begin
			// Mid-run reset brings the word back to its power-up value
			if (i == 8) begin
				rstn <= 1'h0;
				repeat (2) @(posedge sys_clk);
				rstn <= 1'h1;
				e = 32'hdb6db4a2;
				check(config_word, e);
			end
			w = i < 2 ? ~i : $urandom;
			u_host.send(w);
			if (w[1:0] === 2'h2) e = w;
			check(config_word, e);
			{shared_pin_n, ref_leads, fb_leads} <= 3'($urandom);
			repeat (3) @(posedge sys_clk);
			check({pump_source, pump_sink, pump_tristate, pump_midrail_preset, pump_polarity, pump_current_code,
				detector_pulse_width, output_source_select, feedback_source_select, sleep_control_n,
				shared_pin_role, divider_reset}, want_outputs(e, shared_pin_n, ref_leads, fb_leads));
		end
		report_and_stop();
	end
endmodule : test_pll_config_word_two
